// File: shared/arm_pkg.sv
// Constants and types for the rule match enable block
package arm_pkg;
	// ==========================================
	// Rule byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h01;
	localparam logic [7:0] OFS_FIELD = 8'h02;
	localparam logic [7:0] OFS_TYPE = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h06;
	localparam logic [7:0] OFS_PROTO = 8'h0A;
	localparam logic [7:0] OFS_COUNT = 8'h0A;
	localparam logic [7:0] OFS_FWD = 8'h0C;
	localparam logic [7:0] OFS_STAT_HI = 8'h0E;
	localparam logic [7:0] OFS_STAT_LO = 8'h0F;
	localparam int NUM_BYTES = 16;
	// ==========================================
	// Control byte field positions
	localparam int POS_MODE = 4;
	localparam int POS_ENB = 2;
	localparam int POS_SIDE = 1;
	localparam int POS_POL = 0;
	localparam logic [7:0] CTRL_WMASK = 8'h3F;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Forward byte bit positions
	localparam int POS_UNIT_MS = 4;
	localparam int POS_COUNT_UP = 3;
	localparam int COUNT_W = 11;
	// ==========================================
	// Timing
	localparam int CLK_NS = 50;
	localparam int US_NS = 1000;
	localparam int MS_NS = 1000000;
	localparam int US_CYCLES = US_NS / CLK_NS;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	// ==========================================
	// Encodings
	typedef enum logic [1:0] {MODE_OFF, MODE_L2, MODE_L3, MODE_L4} arm_mode_type;
	typedef enum logic [1:0] {ENB_COUNT, ENB_MAC_A, ENB_MAC_B, ENB_BOTH} arm_enb_type;
endpackage

// File: shared/arm_cnt_if.sv
// Link between the rule matcher and its packet counter
`timescale 1ns/100ps
interface arm_cnt_if;
	logic run;
	logic unit_ms;
	logic count_up;
	logic [arm_pkg::COUNT_W-1:0] limit;
	logic hit;
	logic irq;
	logic [arm_pkg::COUNT_W-1:0] count;
	modport ctl (output run, output unit_ms, output count_up, output limit, output hit, input irq, input count);
	modport cnt (input run, input unit_ms, input count_up, input limit, input hit, output irq, output count);
endinterface

// File: rtl/arm_counter.sv
// Packet timer and packet counter of one rule
`timescale 1ns/100ps
module arm_counter
#(
	parameter int MS_CYCLES = arm_pkg::MS_CYCLES
)
(
	input wire logic sys_clk,
	input wire logic rst_sync_n,
	arm_cnt_if.cnt bus
);
	localparam int PRE_W = $clog2(MS_CYCLES + 1);

	if (MS_CYCLES < arm_pkg::US_CYCLES)
		$error("MS_CYCLES must not be below the microsecond count");

	typedef struct packed {
		logic active;
		logic irq;
		logic [PRE_W-1:0] pre;
		logic [arm_pkg::COUNT_W-1:0] count;
	} arm_cnt_state_type;

	arm_cnt_state_type s;
	arm_cnt_state_type next_s;
	logic [PRE_W-1:0] unit_last;

	// ==========================================
	// Counting
	always_comb
	begin
		next_s = s;
		next_s.irq = 1'b0;
		unit_last = bus.unit_ms ? PRE_W'(MS_CYCLES - 1) : PRE_W'(arm_pkg::US_CYCLES - 1);
		if (!bus.run)
		begin
			next_s.active = 1'b0;
			next_s.pre = '0;
			next_s.count = '0;
		end
		else if (bus.count_up)
		begin
			next_s.active = 1'b0;
			if (bus.hit)
			begin
				if ({1'b0, s.count} + 12'h001 >= {1'b0, bus.limit})
				begin
					next_s.irq = 1'b1;
					next_s.count = '0;
				end
				else
					next_s.count = s.count + 11'h001;
			end
		end
		else if (bus.hit)
		begin
			next_s.count = bus.limit;
			next_s.active = (bus.limit != '0);
			next_s.pre = '0;
		end
		else if (s.active)
		begin
			if (s.pre >= unit_last)
			begin
				next_s.pre = '0;
				if (s.count <= 11'h001)
				begin
					next_s.count = '0;
					next_s.active = 1'b0;
					next_s.irq = 1'b1;
				end
				else
					next_s.count = s.count - 11'h001;
			end
			else
				next_s.pre = s.pre + PRE_W'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign bus.irq = s.irq;
	assign bus.count = s.count;

	// ==========================================
	// Checks
	property p_up_wrap;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		bus.run && bus.count_up && bus.hit && ({1'b0, s.count} + 12'h001 >= {1'b0, bus.limit})
		|=> s.irq && s.count == '0;
	endproperty
	a_up_wrap: assert property (p_up_wrap) else $error("count-up terminal did not interrupt and clear");

	property p_load;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		bus.run && !bus.count_up && bus.hit |=> s.count == $past(bus.limit) && !s.irq;
	endproperty
	a_load: assert property (p_load) else $error("countdown not loaded from limit");

	property p_expire;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		bus.run && !bus.count_up && !bus.hit && s.active && s.count == 11'h001 && s.pre >= unit_last
		|=> s.irq && !s.active ##1 !s.irq;
	endproperty
	a_expire: assert property (p_expire) else $error("countdown expiry gave no single interrupt");

	property p_unit;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		bus.run && !bus.unit_ms && s.active |-> s.pre < PRE_W'(arm_pkg::US_CYCLES);
	endproperty
	a_unit: assert property (p_unit) else $error("microsecond prescaler overran");
endmodule

// File: rtl/arm_rule_match.sv
// Rule entry bytes, match enable decoding and packet test of one rule
`timescale 1ns/100ps
module arm_rule_match
#(
	parameter int MS_CYCLES = arm_pkg::MS_CYCLES
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic pkt_valid,
	input wire logic [47:0] pkt_da,
	input wire logic [47:0] pkt_sa,
	input wire logic [15:0] pkt_type,
	input wire logic [31:0] pkt_ip_addr,
	input wire logic [7:0] pkt_ip_proto,
	input wire logic [31:0] pkt_tcp_seq,
	output logic rule_hit,
	output logic count_irq
);
	if (MS_CYCLES < 2)
		$error("MS_CYCLES too small");

	typedef struct packed {
		logic [arm_pkg::NUM_BYTES-1:0][7:0] bytes;
		logic [7:0] rdata;
		logic rvalid;
		logic hit;
	} arm_state_type;

	arm_state_type s;
	arm_state_type next_s;
	logic [1:0] rst_sync;
	logic rst_sync_n;
	arm_cnt_if cbus ();

	// ==========================================
	// Reset release
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_sync_n = rst_sync[1];

	// ==========================================
	// Field helpers
	function automatic logic [15:0] word16(input logic [arm_pkg::NUM_BYTES-1:0][7:0] b, input logic [7:0] ofs);
		word16 = {b[ofs[3:0]], b[ofs[3:0] + 4'h1]};
	endfunction

	function automatic logic [31:0] word32(input logic [arm_pkg::NUM_BYTES-1:0][7:0] b, input logic [7:0] ofs);
		word32 = {word16(b, ofs), word16(b, ofs + 8'h02)};
	endfunction

	logic [7:0] ctrl;
	arm_pkg::arm_mode_type mode;
	arm_pkg::arm_enb_type match_enable_select;
	logic side_sa;
	logic pol_equal;
	logic [47:0] rule_mac;
	logic [47:0] pkt_mac;
	logic mac_eq;
	logic type_eq;
	logic ip_eq;
	logic seq_eq;
	logic cmp;
	logic test_on;
	logic [15:0] limit_word;

	assign ctrl = s.bytes[arm_pkg::OFS_CTRL[3:0]];
	assign mode = arm_pkg::arm_mode_type'(ctrl[arm_pkg::POS_MODE +: 2]);
	assign match_enable_select = arm_pkg::arm_enb_type'(ctrl[arm_pkg::POS_ENB +: 2]);
	assign side_sa = ctrl[arm_pkg::POS_SIDE];
	assign pol_equal = ctrl[arm_pkg::POS_POL];
	assign rule_mac = {word16(s.bytes, arm_pkg::OFS_FIELD), word32(s.bytes, arm_pkg::OFS_FIELD + 8'h02)};
	assign pkt_mac = side_sa ? pkt_sa : pkt_da;
	assign mac_eq = (pkt_mac == rule_mac);
	assign type_eq = (pkt_type == word16(s.bytes, arm_pkg::OFS_TYPE));
	assign ip_eq = ((pkt_ip_addr & word32(s.bytes, arm_pkg::OFS_MASK))
		== (word32(s.bytes, arm_pkg::OFS_FIELD) & word32(s.bytes, arm_pkg::OFS_MASK)))
		|| (pkt_ip_proto == s.bytes[arm_pkg::OFS_PROTO[3:0]]);
	assign seq_eq = (pkt_tcp_seq == word32(s.bytes, arm_pkg::OFS_FIELD));

	// ==========================================
	// Packet test selection
	always_comb
	begin
		cmp = 1'b0;
		test_on = 1'b0;
		case (mode)
			arm_pkg::MODE_L2:
			begin
				test_on = 1'b1;
				case (match_enable_select)
					arm_pkg::ENB_MAC_A: cmp = mac_eq;
					arm_pkg::ENB_MAC_B: cmp = mac_eq;
					default: cmp = mac_eq && type_eq;
				endcase
			end
			arm_pkg::MODE_L3:
			begin
				test_on = (match_enable_select == arm_pkg::ENB_MAC_A);
				cmp = ip_eq;
			end
			arm_pkg::MODE_L4:
			begin
				test_on = (match_enable_select == arm_pkg::ENB_BOTH);
				cmp = seq_eq;
			end
			default:
			begin
				test_on = 1'b0;
				cmp = 1'b0;
			end
		endcase
	end

	// ==========================================
	// Indirect byte access and hit register
	always_comb
	begin
		next_s = s;
		next_s.rvalid = reg_rd;
		next_s.hit = pkt_valid && test_on && (cmp == pol_equal);
		if (reg_wr && reg_addr < arm_pkg::OFS_STAT_HI)
		begin
			if (reg_addr == arm_pkg::OFS_CTRL)
				next_s.bytes[reg_addr[3:0]] = reg_wdata & arm_pkg::CTRL_WMASK;
			else
				next_s.bytes[reg_addr[3:0]] = reg_wdata;
		end
		if (reg_rd)
		begin
			if (reg_addr == arm_pkg::OFS_STAT_HI)
				next_s.rdata = {5'h00, cbus.count[10:8]};
			else if (reg_addr == arm_pkg::OFS_STAT_LO)
				next_s.rdata = cbus.count[7:0];
			else if (reg_addr < arm_pkg::OFS_STAT_HI)
				next_s.rdata = s.bytes[reg_addr[3:0]];
			else
				next_s.rdata = 8'h00;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			s <= '0;
		else
			s <= next_s;
	end

	// ==========================================
	// Counter configuration
	assign cbus.run = (mode == arm_pkg::MODE_L2) && (match_enable_select == arm_pkg::ENB_COUNT);
	assign cbus.unit_ms = s.bytes[arm_pkg::OFS_FWD[3:0]][arm_pkg::POS_UNIT_MS];
	assign cbus.count_up = s.bytes[arm_pkg::OFS_FWD[3:0]][arm_pkg::POS_COUNT_UP];
	assign limit_word = word16(s.bytes, arm_pkg::OFS_COUNT);
	assign cbus.limit = limit_word[arm_pkg::COUNT_W-1:0];
	assign cbus.hit = s.hit;

	arm_counter #(.MS_CYCLES(MS_CYCLES)) u_counter
	(
		.sys_clk(sys_clk),
		.rst_sync_n(rst_sync_n),
		.bus(cbus.cnt)
	);

	assign reg_rdata = s.rdata;
	assign reg_rvalid = s.rvalid;
	assign rule_hit = s.hit;
	assign count_irq = cbus.irq;

	// ==========================================
	// Checks
	property p_off;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		pkt_valid && mode == arm_pkg::MODE_OFF |=> !rule_hit;
	endproperty
	a_off: assert property (p_off) else $error("disabled rule produced a hit");

	property p_l3_reserved;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		pkt_valid && mode == arm_pkg::MODE_L3 && match_enable_select == arm_pkg::ENB_COUNT |=> !rule_hit;
	endproperty
	a_l3_reserved: assert property (p_l3_reserved) else $error("reserved layer-3 select hit");

	property p_source_side;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		pkt_valid && mode == arm_pkg::MODE_L2 && match_enable_select == arm_pkg::ENB_MAC_A && pol_equal
		&& side_sa && pkt_sa == rule_mac |=> rule_hit;
	endproperty
	a_source_side: assert property (p_source_side) else $error("source MAC match missed");

	property p_mac_type;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		pkt_valid && mode == arm_pkg::MODE_L2 && match_enable_select == arm_pkg::ENB_BOTH && pol_equal
		&& !type_eq |=> !rule_hit;
	endproperty
	a_mac_type: assert property (p_mac_type) else $error("type mismatch still hit");

	property p_seq;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		pkt_valid && mode == arm_pkg::MODE_L4 && match_enable_select == arm_pkg::ENB_BOTH
		|=> rule_hit == ($past(seq_eq) == $past(pol_equal));
	endproperty
	a_seq: assert property (p_seq) else $error("sequence compare wrong");

	property p_polarity;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		pkt_valid && mode == arm_pkg::MODE_L2 && match_enable_select == arm_pkg::ENB_MAC_B && !pol_equal
		&& mac_eq |=> !rule_hit;
	endproperty
	a_polarity: assert property (p_polarity) else $error("differ polarity hit on equal");

	property p_count_feed;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		pkt_valid && cbus.run && mac_eq && type_eq && pol_equal
		|=> cbus.hit ##1 (cbus.irq || cbus.count != 11'h000 || cbus.limit == 11'h000 || !$past(cbus.run));
	endproperty
	a_count_feed: assert property (p_count_feed) else $error("counting match not passed on");
endmodule

// File: verif/arm_rule_match_tb.sv
// Self-checking testbench of the rule match enable block
`timescale 1ns/100ps
module arm_rule_match_tb;
	// ==========================================
	// Signals and design
	logic sys_clk;
	logic rst_n;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic pkt_valid;
	logic [47:0] pkt_da;
	logic [47:0] pkt_sa;
	logic [15:0] pkt_type;
	logic [31:0] pkt_ip_addr;
	logic [7:0] pkt_ip_proto;
	logic [31:0] pkt_tcp_seq;
	logic rule_hit;
	logic count_irq;
	int errors;
	int cmp_count;
	localparam logic [47:0] MAC = 48'h001122334455;
	localparam logic [47:0] OTHER = 48'h0A0B0C0D0E0F;

	arm_rule_match #(.MS_CYCLES(40)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.pkt_valid(pkt_valid), .pkt_da(pkt_da), .pkt_sa(pkt_sa), .pkt_type(pkt_type), .pkt_ip_addr(pkt_ip_addr),
		.pkt_ip_proto(pkt_ip_proto), .pkt_tcp_seq(pkt_tcp_seq), .rule_hit(rule_hit), .count_irq(count_irq));

	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ==========================================
	// Tasks
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask

	// Writes n bytes big endian starting at offset a
	task automatic wrn(input logic [7:0] a, input int n, input logic [47:0] v);
		for (int i = 0; i < n; i++)
			wr(a + 8'(i), 8'(v >> (8 * (n - 1 - i))));
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		chk(reg_rvalid, 1'b1);
		chk(reg_rdata, exp);
	endtask

	// One packet from the current fields; checks hit and the following interrupt cycle
	task automatic pkt(input logic exp_hit, input logic exp_irq);
		@(negedge sys_clk);
		pkt_valid = 1'b1;
		@(negedge sys_clk);
		pkt_valid = 1'b0;
		chk(rule_hit, exp_hit);
		@(negedge sys_clk);
		chk(count_irq, exp_irq);
	endtask

	task automatic wait_irq(input int lo, input int hi);
		int n;
		n = 0;
		while (count_irq !== 1'b1 && n < 200)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 200)
		begin
			errors++;
			summarize();
		end
		else
			chk(n >= lo && n <= hi, 1'b1);
	endtask

	// ==========================================
	// Sequence
	initial
	begin
		errors = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		pkt_valid = 1'b0;
		pkt_da = OTHER;
		pkt_sa = OTHER;
		pkt_type = 16'h0000;
		pkt_ip_addr = 32'h00000000;
		pkt_ip_proto = 8'h00;
		pkt_tcp_seq = 32'h00000000;
		repeat (5) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		rd(8'h01, 8'h00);
		wr(8'h01, 8'hFF);
		rd(8'h01, 8'h3F);
		wr(8'h0E, 8'h55);
		rd(8'h0E, 8'h00);
		rd(8'h10, 8'h00);
		$display("Test registers done");
		wrn(8'h02, 6, MAC);
		wrn(8'h08, 2, 48'h0800);
		wr(8'h01, 8'h0D);
		pkt_da = MAC;
		pkt_type = 16'h0800;
		pkt(1'b0, 1'b0);
		wr(8'h01, 8'h15);
		pkt(1'b1, 1'b0);
		pkt_da = OTHER;
		pkt_sa = MAC;
		pkt(1'b0, 1'b0);
		wr(8'h01, 8'h17);
		pkt(1'b1, 1'b0);
		wr(8'h01, 8'h16);
		pkt(1'b0, 1'b0);
		pkt_sa = OTHER;
		pkt(1'b1, 1'b0);
		pkt_da = MAC;
		wr(8'h01, 8'h19);
		pkt(1'b1, 1'b0);
		wr(8'h01, 8'h1D);
		pkt(1'b1, 1'b0);
		pkt_type = 16'h86DD;
		pkt(1'b0, 1'b0);
		$display("Test layer 2 done");
		wrn(8'h02, 4, 48'hC0A80101);
		wrn(8'h06, 4, 48'hFFFFFF00);
		wr(8'h0A, 8'h06);
		wr(8'h01, 8'h25);
		pkt_ip_addr = 32'hC0A801FE;
		pkt_ip_proto = 8'h11;
		pkt(1'b1, 1'b0);
		pkt_ip_addr = 32'h0A000001;
		pkt_ip_proto = 8'h06;
		pkt(1'b1, 1'b0);
		pkt_ip_proto = 8'h11;
		pkt(1'b0, 1'b0);
		pkt_ip_addr = 32'hC0A80101;
		wr(8'h01, 8'h21);
		pkt(1'b0, 1'b0);
		wrn(8'h02, 4, 48'h12345678);
		wr(8'h01, 8'h3D);
		pkt_tcp_seq = 32'h12345678;
		pkt(1'b1, 1'b0);
		wr(8'h01, 8'h31);
		pkt(1'b0, 1'b0);
		wr(8'h01, 8'h3C);
		pkt_tcp_seq = 32'h12345679;
		pkt(1'b1, 1'b0);
		$display("Test layer 3 and 4 done");
		wrn(8'h02, 6, MAC);
		wrn(8'h08, 2, 48'h0800);
		wrn(8'h0A, 2, 48'h0002);
		wr(8'h0C, 8'h08);
		wr(8'h01, 8'h11);
		pkt_type = 16'h86DD;
		pkt(1'b0, 1'b0);
		pkt_type = 16'h0800;
		pkt(1'b1, 1'b0);
		rd(8'h0F, 8'h01);
		pkt(1'b1, 1'b1);
		rd(8'h0F, 8'h00);
		$display("Test count up done");
		wr(8'h0C, 8'h00);
		pkt(1'b1, 1'b0);
		wait_irq(30, 45);
		pkt(1'b1, 1'b0);
		repeat (25) @(negedge sys_clk);
		chk(count_irq, 1'b0);
		pkt(1'b1, 1'b0);
		wait_irq(30, 45);
		wr(8'h0C, 8'h10);
		pkt(1'b1, 1'b0);
		wait_irq(70, 90);
		$display("Test countdown done");
		summarize();
	end
endmodule
